// File: logic/ect_capture_timer.sv
`timescale 1ns/1ps
`include "ect_regs.svh"
// Behaviour
// - eight channels, clear select bit picks capture
// - 16-bit main counter, 7-bit prescaler
// - four channels add a holding register
// - capture empty after read or transfer
// - holding register empty only after read
// - valid edge stores counter, newer replaces
// - guard set: plain capture only when empty
// - latch mode copies on modulus zero events
// - latch mode without guard overwrites holding
// - buffered guard: each register only when empty
// - queue mode shifts capture into holding
// - queue hold read latches, clears accumulator
// - four 8-bit edge accumulators with holding
// - saturation bit stops unpaired accumulators at max
// - accumulator pairs form 16-bit counters
// - latch events in latch mode copy and clear accumulators
// - 16-bit modulus down-counter, 4-bit prescaler
// - modulus latching periodic or only once
// - selectable input delay rejects glitches
module ect_capture_timer (
  input wire logic mclk,           // module clock, 20 MHz
  input wire logic sys_rst,        // sync reset, active high
  input wire logic psel,           // apb select
  input wire logic penable,        // apb enable
  input wire logic pwrite,         // apb direction
  input wire logic [11:0] paddr,   // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [7:0] capPin,   // capture input pins
  output logic [31:0] prdata,      // apb read data
  output logic pready,             // apb ready
  output logic pslverr,            // apb error, unmapped
  output logic modZeroFlag         // modulus reached zero
);
  ect_evt_if evt ();

  logic [7:0] chSel, ovw, capFull;
  logic [2:0] tPs;
  logic tEn, latch_queue_select, sat, pair0, pair1;
  logic modEn, modReload, modLatEn, modFlag;
  logic [3:0] modPs, holdFull;
  logic [1:0] dlySel;
  logic [15:0] edgeCfg;
  ect_pkg::ect_word_t count, modCnt, modLoad;
  ect_pkg::ect_word_t cap [8];
  ect_pkg::ect_word_t hold [4];
  ect_pkg::ect_byte_t acc [4];
  ect_pkg::ect_byte_t accHold [4];

  logic [7:0] next_chSel, next_ovw, next_capFull;
  logic [2:0] next_tPs;
  logic next_tEn, next_latch_queue_select, next_sat, next_pair0, next_pair1;
  logic next_modEn, next_modReload, next_modLatEn, next_modFlag;
  logic [3:0] next_modPs, next_holdFull;
  logic [1:0] next_dlySel;
  logic [15:0] next_edgeCfg;
  ect_pkg::ect_word_t next_count, next_modCnt, next_modLoad;
  ect_pkg::ect_word_t next_cap [8];
  ect_pkg::ect_word_t next_hold [4];
  ect_pkg::ect_byte_t next_acc [4];
  ect_pkg::ect_byte_t next_accHold [4];
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  logic wrEn, rdStrobe, latchEvt, zeroEvt, hit;
  logic [31:0] rdData;
  logic [8:0] incLo;

  // mapped-address test shared by the read mux and the read side effects
  function automatic logic inRange(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input logic [11:0] words);
    inRange = (a >= base) && (a < base + (words << 2));
  endfunction

  function automatic ect_pkg::ect_byte_t bump(
      input ect_pkg::ect_byte_t v, input logic satOn);
    if (satOn && v == 8'hFF) bump = v;
    else bump = v + 8'h01;
  endfunction

  ect_input_filter #(.NCH(8)) uFilt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinIn(capPin),
    .edgeCfg(edgeCfg),
    .dlySel(dlySel),
    .evt(evt)
  );

  ect_prescaler uPre (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .timerEn(tEn),
    .tPs(tPs),
    .modEn(modEn),
    .modPs(modPs),
    .evt(evt)
  );

  // ==========================================================
  // register read mux
  always_comb begin
    rdData = 32'h0000_0000;
    hit = 1'b1;
    if (paddr[1:0] != 2'h0) hit = 1'b0;
    else if (paddr == `ECT_OFF_CHSEL) rdData = {24'h0, chSel};
    else if (paddr == `ECT_OFF_TSCR)
      rdData = {24'h0, tEn, 4'h0, tPs};
    else if (paddr == `ECT_OFF_COUNT) rdData = {16'h0, count};
    else if (paddr == `ECT_OFF_EDGE) rdData = {16'h0, edgeCfg};
    else if (paddr == `ECT_OFF_OVW) rdData = {24'h0, ovw};
    else if (paddr == `ECT_OFF_SYS)
      rdData = {28'h0, pair1, pair0, sat, latch_queue_select};
    else if (paddr == `ECT_OFF_MODCTL)
      rdData = {24'h0, modPs, 1'b0, modLatEn, modReload, modEn};
    else if (paddr == `ECT_OFF_MODCNT) rdData = {16'h0, modCnt};
    else if (paddr == `ECT_OFF_MODFLG) rdData = {31'h0, modFlag};
    else if (paddr == `ECT_OFF_DELAY) rdData = {30'h0, dlySel};
    else if (paddr == `ECT_OFF_STATUS)
      rdData = {20'h0, holdFull, capFull};
    else if (inRange(paddr, `ECT_OFF_CAP, 12'h008))
      rdData = {16'h0, cap[paddr[4:2]]};
    else if (inRange(paddr, `ECT_OFF_HOLD, 12'h004))
      rdData = {16'h0, hold[paddr[3:2]]};
    else if (inRange(paddr, `ECT_OFF_ACC, 12'h004))
      rdData = {24'h0, acc[paddr[3:2]]};
    else if (inRange(paddr, `ECT_OFF_ACCH, 12'h004))
      rdData = {24'h0, accHold[paddr[3:2]]};
    else hit = 1'b0;
  end

  // ==========================================================
  // apb handshake: one wait state, data ready with pready
  always_comb begin
    rdStrobe = psel && penable && !pready && !pwrite;
    wrEn = psel && penable && pready && pwrite && !pslverr;
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !hit;
    next_prdata = rdStrobe && hit ? rdData : 32'h0000_0000;
  end

  // ==========================================================
  // control, counters, capture and accumulators
  always_comb begin
    next_chSel = chSel;
    next_tEn = tEn;
    next_tPs = tPs;
    next_edgeCfg = edgeCfg;
    next_ovw = ovw;
    next_latch_queue_select = latch_queue_select;
    next_sat = sat;
    next_pair0 = pair0;
    next_pair1 = pair1;
    next_modEn = modEn;
    next_modReload = modReload;
    next_modLatEn = modLatEn;
    next_modPs = modPs;
    next_dlySel = dlySel;
    next_modLoad = modLoad;
    next_modFlag = modFlag;
    next_count = count;
    next_modCnt = modCnt;
    next_cap = cap;
    next_capFull = capFull;
    next_hold = hold;
    next_holdFull = holdFull;
    next_acc = acc;
    next_accHold = accHold;
    latchEvt = 1'b0;
    zeroEvt = 1'b0;
    incLo = 9'h000;

    if (evt.timerTick) next_count = count + 16'h0001;

    // modulus down-counter; reload off stops it at zero
    if (modEn && evt.modTick && modCnt != 16'h0000) begin
      next_modCnt = modCnt - 16'h0001;
      if (modCnt == 16'h0001) begin
        zeroEvt = 1'b1;
        next_modCnt = modReload ? modLoad : 16'h0000;
      end
    end
    if (zeroEvt && modLatEn) latchEvt = 1'b1;

    if (wrEn) begin
      case (paddr)
        `ECT_OFF_CHSEL: next_chSel = pwdata[7:0];
        `ECT_OFF_TSCR: begin
          next_tEn = pwdata[`ECT_TSCR_EN];
          next_tPs = pwdata[`ECT_TSCR_PS_LSB +: 3];
        end
        `ECT_OFF_EDGE: next_edgeCfg = pwdata[15:0];
        `ECT_OFF_OVW: next_ovw = pwdata[7:0];
        `ECT_OFF_SYS: begin
          next_latch_queue_select = pwdata[`ECT_SYS_LATCH_QUEUE_SELECT];
          next_sat = pwdata[`ECT_SYS_SAT];
          next_pair0 = pwdata[`ECT_SYS_PAIR0];
          next_pair1 = pwdata[`ECT_SYS_PAIR1];
        end
        `ECT_OFF_MODCTL: begin
          next_modEn = pwdata[`ECT_MOD_EN];
          next_modReload = pwdata[`ECT_MOD_RELOAD];
          next_modLatEn = pwdata[`ECT_MOD_LATEN];
          next_modPs = pwdata[`ECT_MOD_PS_LSB +: 4];
          // force-latch bit is a strobe, never stored
          if (pwdata[`ECT_MOD_FLAT]) latchEvt = 1'b1;
        end
        `ECT_OFF_MODCNT: begin
          next_modLoad = pwdata[15:0];
          next_modCnt = pwdata[15:0];
          if (pwdata[15:0] == 16'h0000) latchEvt = 1'b1;
        end
        `ECT_OFF_MODFLG: if (pwdata[0]) next_modFlag = 1'b0;
        `ECT_OFF_DELAY: next_dlySel = pwdata[1:0];
        default: ;
      endcase
    end
    if (zeroEvt) next_modFlag = 1'b1;  // set beats a clear

    // read side effects come first so events in this cycle win
    if (rdStrobe && inRange(paddr, `ECT_OFF_CAP, 12'h008))
      next_capFull[paddr[4:2]] = 1'b0;
    if (rdStrobe && inRange(paddr, `ECT_OFF_HOLD, 12'h004)) begin
      next_holdFull[paddr[3:2]] = 1'b0;
      if (!latch_queue_select) begin
        next_accHold[paddr[3:2]] = acc[paddr[3:2]];
        next_acc[paddr[3:2]] = 8'h00;
      end
    end

    // latch mode transfers to the holding registers
    if (latchEvt && latch_queue_select) begin
      for (int k = 0; k < 4; k++) begin
        if (!ovw[k] || !next_holdFull[k]) begin
          next_hold[k] = cap[k];
          next_holdFull[k] = 1'b1;
          next_capFull[k] = 1'b0;
        end  // blocked latch leaves both untouched
        next_accHold[k] = acc[k];
        next_acc[k] = 8'h00;
      end
    end

    // captures on filtered edges
    for (int i = 0; i < 8; i++) begin
      if (evt.capEdge[i] && !chSel[i]) begin
        if (i < 4 && !latch_queue_select) begin
          // queue: old capture moves down first
          if (!ovw[i] || !next_capFull[i]) begin
            if (next_capFull[i] || !ovw[i]) begin
              next_hold[i[1:0]] = next_cap[i];
              next_holdFull[i[1:0]] = next_capFull[i] | next_holdFull[i[1:0]];
            end
            next_cap[i] = count;
            next_capFull[i] = 1'b1;
          end else if (!next_holdFull[i[1:0]]) begin
            next_hold[i[1:0]] = next_cap[i];
            next_holdFull[i[1:0]] = 1'b1;
            next_cap[i] = count;
          end  // both full and guarded: dropped
        end else if (!ovw[i] || !next_capFull[i]) begin
          next_cap[i] = count;
          next_capFull[i] = 1'b1;
        end
      end
    end

    // pulse accumulators; the lower channel drives a pair
    for (int p = 0; p < 2; p++) begin
      if ((p == 0) ? pair0 : pair1) begin
        if (evt.capEdge[2*p]) begin
          incLo = {1'b0, next_acc[2*p]} + 9'h001;
          next_acc[2*p] = incLo[7:0];
          if (incLo[8]) next_acc[2*p+1] = next_acc[2*p+1] + 8'h01;
        end
      end else begin
        for (int q = 0; q < 2; q++) begin
          if (evt.capEdge[2*p+q])
            next_acc[2*p+q] = bump(next_acc[2*p+q], sat);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chSel <= `ECT_RST_BYTE;
      ovw <= `ECT_RST_BYTE;
      capFull <= `ECT_RST_BYTE;
      tEn <= 1'b0;
      tPs <= 3'h0;
      edgeCfg <= `ECT_RST_EDGE;
      latch_queue_select <= 1'b0;
      sat <= 1'b0;
      pair0 <= 1'b0;
      pair1 <= 1'b0;
      modEn <= 1'b0;
      modReload <= 1'b0;
      modLatEn <= 1'b0;
      modPs <= 4'h0;
      modFlag <= 1'b0;
      dlySel <= 2'h0;
      holdFull <= 4'h0;
      count <= `ECT_RST_WORD;
      modCnt <= `ECT_RST_WORD;
      modLoad <= `ECT_RST_WORD;
      for (int i = 0; i < 8; i++) cap[i] <= `ECT_RST_WORD;
      for (int k = 0; k < 4; k++) begin
        hold[k] <= `ECT_RST_WORD;
        acc[k] <= `ECT_RST_BYTE;
        accHold[k] <= `ECT_RST_BYTE;
      end
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      modZeroFlag <= 1'b0;
    end else begin
      chSel <= next_chSel;
      ovw <= next_ovw;
      capFull <= next_capFull;
      tEn <= next_tEn;
      tPs <= next_tPs;
      edgeCfg <= next_edgeCfg;
      latch_queue_select <= next_latch_queue_select;
      sat <= next_sat;
      pair0 <= next_pair0;
      pair1 <= next_pair1;
      modEn <= next_modEn;
      modReload <= next_modReload;
      modLatEn <= next_modLatEn;
      modPs <= next_modPs;
      modFlag <= next_modFlag;
      dlySel <= next_dlySel;
      holdFull <= next_holdFull;
      count <= next_count;
      modCnt <= next_modCnt;
      modLoad <= next_modLoad;
      cap <= next_cap;
      hold <= next_hold;
      acc <= next_acc;
      accHold <= next_accHold;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      modZeroFlag <= next_modFlag;
    end
  end
endmodule

// File: logic/ect_evt_if.sv
`timescale 1ns/1ps
interface ect_evt_if;
  logic [7:0] capEdge;
  logic timerTick;
  logic modTick;
  modport filt(output capEdge);
  modport pre(output timerTick, output modTick);
  modport core(input capEdge, input timerTick, input modTick);
endinterface

// File: logic/ect_input_filter.sv
`timescale 1ns/1ps
`include "ect_regs.svh"
module ect_input_filter #(
  parameter int NCH = 8
) (
  input wire logic mclk,             // module clock
  input wire logic sys_rst,          // sync reset
  input wire logic [NCH-1:0] pinIn,  // raw capture pins
  input wire logic [15:0] edgeCfg,   // 2 bits per channel
  input wire logic [1:0] dlySel,     // delay counter select
  ect_evt_if.filt evt                // filtered edge pulses
);
  localparam logic [7:0] DLY1 = 8'(`ECT_NS_TO_CYC(`ECT_DLY1_NS));
  localparam logic [7:0] DLY2 = 8'(`ECT_NS_TO_CYC(`ECT_DLY2_NS));
  localparam logic [7:0] DLY3 = 8'(`ECT_NS_TO_CYC(`ECT_DLY3_NS));

  logic [NCH-1:0] s1, s2, s3, lvl, edgeQ;
  logic [NCH-1:0] next_lvl, next_edgeQ;
  logic [7:0] cnt [NCH];
  logic [7:0] next_cnt [NCH];
  logic [7:0] limit;

  function automatic logic edgeHit(input logic [1:0] cfg,
                                   input logic newLvl);
    ect_pkg::ect_edge_t m;
    m = ect_pkg::ect_edge_t'(cfg);
    case (m)
      ect_pkg::ECT_EDGE_RISE: edgeHit = newLvl;
      ect_pkg::ECT_EDGE_FALL: edgeHit = !newLvl;
      ect_pkg::ECT_EDGE_ANY: edgeHit = 1'b1;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // delay counters
  always_comb begin
    case (dlySel)
      2'h1: limit = DLY1;
      2'h2: limit = DLY2;
      2'h3: limit = DLY3;
      default: limit = 8'h00;
    endcase
    next_lvl = lvl;
    next_edgeQ = '0;
    next_cnt = cnt;
    for (int i = 0; i < NCH; i++) begin
      // level counts only once two late stages agree
      if (s2[i] == s3[i] && s3[i] != lvl[i]) begin
        if (cnt[i] + 8'h01 >= limit) begin
          next_lvl[i] = s3[i];
          next_edgeQ[i] = edgeHit(edgeCfg[2*i +: 2], s3[i]);
          next_cnt[i] = 8'h00;
        end else begin
          next_cnt[i] = cnt[i] + 8'h01;
        end
      end else begin
        next_cnt[i] = 8'h00;  // short glitch restarts the delay
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
      edgeQ <= '0;
      for (int i = 0; i < NCH; i++) cnt[i] <= 8'h00;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      edgeQ <= next_edgeQ;
      cnt <= next_cnt;
    end
  end

  assign evt.capEdge = edgeQ;
endmodule

// File: logic/ect_pkg.sv
package ect_pkg;
  typedef logic [15:0] ect_word_t;
  typedef logic [7:0] ect_byte_t;
  typedef enum logic [1:0] {
    ECT_EDGE_OFF,
    ECT_EDGE_RISE,
    ECT_EDGE_FALL,
    ECT_EDGE_ANY
  } ect_edge_t;
endpackage

// File: logic/ect_prescaler.sv
`timescale 1ns/1ps
module ect_prescaler (
  input wire logic mclk,          // module clock
  input wire logic sys_rst,       // sync reset
  input wire logic timerEn,       // main timer enable
  input wire logic [2:0] tPs,     // main divide 2**tPs
  input wire logic modEn,         // modulus counter enable
  input wire logic [3:0] modPs,   // modulus divide modPs+1
  ect_evt_if.pre evt              // tick enables
);
  logic [6:0] tCnt, next_tCnt;
  logic [3:0] mCnt, next_mCnt;
  logic tTick, next_tTick, mTick, next_mTick;
  logic [6:0] mask;

  // ==========================================================
  // dividers
  always_comb begin
    mask = 7'((8'h01 << tPs) - 8'h01);
    next_tCnt = timerEn ? tCnt + 7'h01 : 7'h00;
    next_tTick = timerEn && ((tCnt & mask) == mask);
    next_mCnt = 4'h0;
    next_mTick = 1'b0;
    if (modEn) begin
      next_mTick = (mCnt == modPs);
      next_mCnt = (mCnt == modPs) ? 4'h0 : mCnt + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tCnt <= 7'h00;
      mCnt <= 4'h0;
      tTick <= 1'b0;
      mTick <= 1'b0;
    end else begin
      tCnt <= next_tCnt;
      mCnt <= next_mCnt;
      tTick <= next_tTick;
      mTick <= next_mTick;
    end
  end

  assign evt.timerTick = tTick;
  assign evt.modTick = mTick;
endmodule

// File: logic/ect_regs.svh
`ifndef ECT_REGS_SVH
`define ECT_REGS_SVH

// ==========================================================
// register byte offsets, one 32-bit word each, arrays one word per entry
`define ECT_OFF_CHSEL 12'h000
`define ECT_OFF_TSCR 12'h004
`define ECT_OFF_COUNT 12'h008
`define ECT_OFF_EDGE 12'h00C
`define ECT_OFF_OVW 12'h010
`define ECT_OFF_SYS 12'h014
`define ECT_OFF_MODCTL 12'h018
`define ECT_OFF_MODCNT 12'h01C
`define ECT_OFF_MODFLG 12'h020
`define ECT_OFF_DELAY 12'h024
`define ECT_OFF_STATUS 12'h028
`define ECT_OFF_CAP 12'h040
`define ECT_OFF_HOLD 12'h060
`define ECT_OFF_ACC 12'h070
`define ECT_OFF_ACCH 12'h080

// ==========================================================
// field positions
`define ECT_TSCR_EN 7
`define ECT_TSCR_PS_LSB 0
`define ECT_SYS_LATCH_QUEUE_SELECT 0
`define ECT_SYS_SAT 1
`define ECT_SYS_PAIR0 2
`define ECT_SYS_PAIR1 3
`define ECT_MOD_EN 0
`define ECT_MOD_RELOAD 1
`define ECT_MOD_LATEN 2
`define ECT_MOD_FLAT 3
`define ECT_MOD_PS_LSB 4

// ==========================================================
// reset values
`define ECT_RST_BYTE 8'h00
`define ECT_RST_WORD 16'h0000
`define ECT_RST_EDGE 16'h0000

// ==========================================================
// timing
`define ECT_MCLK_MHZ 20
`define ECT_DLY1_NS 800
`define ECT_DLY2_NS 1600
`define ECT_DLY3_NS 3200
`define ECT_NS_TO_CYC(ns) ((((ns) * `ECT_MCLK_MHZ) + 999) / 1000)

`endif

// File: verif/ect_capture_timer_sva.sv
`timescale 1ns/1ps
`include "ect_regs.svh"
module ect_capture_timer_sva (
  input wire logic mclk,           // module clock
  input wire logic sys_rst,        // sync reset
  input wire logic psel,           // apb select
  input wire logic penable,        // apb enable
  input wire logic pwrite,         // apb direction
  input wire logic [11:0] paddr,   // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [7:0] capPin,   // capture pins
  input wire logic [31:0] prdata,  // apb read data
  input wire logic pready,         // apb ready
  input wire logic pslverr,        // apb error
  input wire logic modZeroFlag     // modulus zero flag
);
  // ==========================================================
  // helpers
  logic clrWr;
  assign clrWr = psel && penable && pready && pwrite &&
    (paddr == `ECT_OFF_MODFLG) && pwdata[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // bus timing: one wait state, answer stands one cycle
  a_setup_no_ready: assert property (psel && !penable |-> !pready)
    else $error("ready during setup cycle");
  a_access_wait: assert property ($rose(penable) && psel |->
    !pready ##1 pready)
    else $error("access phase not exactly two cycles");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_misalign: assert property (psel && penable && pready &&
    paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_data_zero: assert property (pslverr |->
    prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_idle_data_zero: assert property (!pready |->
    prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  // flag only drops through a clear write, seen one or two edges late
  a_flag_clear: assert property ($fell(modZeroFlag) |->
    $past(clrWr, 1) || $past(clrWr, 2))
    else $error("zero flag dropped without clear");

  c_read: cover property (psel && penable && pready && !pwrite);
  c_write: cover property (psel && penable && pready && pwrite);
  c_refused: cover property (pslverr);
  c_zero: cover property ($rose(modZeroFlag));
endmodule

bind ect_capture_timer ect_capture_timer_sva chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .capPin(capPin),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .modZeroFlag(modZeroFlag)
);

// File: verif/ect_capture_timer_test.sv
`timescale 1ns/1ps
`include "ect_regs.svh"
module ect_capture_timer_test;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic modZeroFlag, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, mid, w0;
  logic [7:0] capPin;
  logic [11:0] offs [9];
  int errors, checks_done;

  ect_capture_timer uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .capPin(capPin), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modZeroFlag(modZeroFlag));
  ect_pin_model pins (.mclk(mclk), .capPin(capPin));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================
  // reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // pulses, then room for sync, filter and store
  task automatic pz(input int ch, input int n);
    pins.pulse(ch, n, 4);
    repeat (12) @(posedge mclk);
  endtask

  task automatic two(input int ch);
    pz(ch, 1);
    rd(`ECT_OFF_COUNT);
    mid = v;
    pz(ch, 1);
  endtask

  task automatic wait_flag();
    for (int n = 0; n < 80 && modZeroFlag !== 1'b1; n++) @(posedge mclk);
    chk("zero flag", 32'(modZeroFlag), 32'h1);
    if (modZeroFlag !== 1'b1) finish_test();
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    $display("mismatch run length expected done seen running");
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errors = 0;
    checks_done = 0;
    offs = '{`ECT_OFF_CHSEL, `ECT_OFF_TSCR, `ECT_OFF_COUNT, `ECT_OFF_EDGE,
      `ECT_OFF_OVW, `ECT_OFF_SYS, `ECT_OFF_MODCTL, `ECT_OFF_MODFLG,
      `ECT_OFF_STATUS};
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", v, 32'h0000_0000);
    end
    rd(12'h002);
    chk("misaligned err", 32'(err), 32'h1);
    rd(12'hFFC);
    chk("unmapped data", v, 32'h0000_0000);
    wr(`ECT_OFF_COUNT, 32'h0000_1234);
    rd(`ECT_OFF_COUNT);
    chk("count read only", v, 32'h0000_0000);
    $display("test reset done");

    wr(`ECT_OFF_TSCR, 32'h0000_0080);
    rd(`ECT_OFF_COUNT);
    mid = v;
    rd(`ECT_OFF_COUNT);
    chk("count step div1", v - mid, 32'h4);
    wr(`ECT_OFF_TSCR, 32'h0000_0082);
    rd(`ECT_OFF_COUNT);
    mid = v;
    rd(`ECT_OFF_COUNT);
    chk("count step div4", v - mid, 32'h1);
    wr(`ECT_OFF_TSCR, 32'h0000_0080);
    $display("test counter done");

    wr(`ECT_OFF_EDGE, 32'h0000_15D5);
    rd(`ECT_OFF_COUNT);
    mid = v;
    pz(4, 1);
    rd(`ECT_OFF_STATUS);
    chk("cap4 full", 32'(v[4]), 32'h1);
    rd(`ECT_OFF_CAP + 12'h010);
    chk("cap4 value", 32'(v[15:0] > mid[15:0]), 32'h1);
    rd(`ECT_OFF_STATUS);
    chk("cap4 emptied", 32'(v[4]), 32'h0);
    two(4);
    rd(`ECT_OFF_CAP + 12'h010);
    chk("cap4 newer", 32'(v[15:0] > mid[15:0]), 32'h1);
    wr(`ECT_OFF_OVW, 32'h0000_0010);
    two(4);
    rd(`ECT_OFF_CAP + 12'h010);
    chk("cap4 kept", 32'(v[15:0] < mid[15:0]), 32'h1);
    wr(`ECT_OFF_CHSEL, 32'h0000_0020);
    pz(5, 1);
    rd(`ECT_OFF_STATUS);
    chk("compare no cap", 32'(v[5]), 32'h0);
    pz(7, 1);
    pz(3, 1);
    rd(`ECT_OFF_STATUS);
    chk("edge off", 32'(v[7]), 32'h0);
    rd(`ECT_OFF_ACC + 12'h00C);
    chk("any edge count", v, 32'h2);
    $display("test plain capture done");

    two(0);
    rd(`ECT_OFF_CAP);
    chk("queue cap0", 32'(v[15:0] > mid[15:0]), 32'h1);
    rd(`ECT_OFF_ACC);
    chk("acc0 count", v, 32'h2);
    rd(`ECT_OFF_HOLD);
    chk("queue hold0", 32'(v[15:0] < mid[15:0]), 32'h1);
    rd(`ECT_OFF_ACCH);
    chk("acch0 copy", v, 32'h2);
    rd(`ECT_OFF_ACC);
    chk("acc0 cleared", v, 32'h0);
    $display("test queue done");

    wr(`ECT_OFF_SYS, 32'h0000_0001);
    pz(1, 3);
    wr(`ECT_OFF_MODCTL, 32'h0000_0008);
    rd(`ECT_OFF_CAP + 12'h004);
    w0 = v;
    rd(`ECT_OFF_ACCH + 12'h004);
    chk("acch1 force", v, 32'h3);
    rd(`ECT_OFF_ACC + 12'h004);
    chk("acc1 cleared", v, 32'h0);
    rd(`ECT_OFF_STATUS);
    chk("hold1 still full", 32'(v[9]), 32'h1);
    pz(1, 2);
    wr(`ECT_OFF_MODCNT, 32'h0000_0000);
    rd(`ECT_OFF_HOLD + 12'h004);
    chk("hold1 overwrite", 32'(v[15:0] > w0[15:0]), 32'h1);
    mid = v;
    rd(`ECT_OFF_CAP + 12'h004);
    chk("hold1 equals cap1", v, mid);
    rd(`ECT_OFF_ACCH + 12'h004);
    chk("acch1 zero write", v, 32'h2);
    wr(`ECT_OFF_OVW, 32'h0000_0002);
    pz(1, 1);
    wr(`ECT_OFF_MODCTL, 32'h0000_0008);
    rd(`ECT_OFF_COUNT);
    mid = v;
    pz(1, 1);
    wr(`ECT_OFF_MODCTL, 32'h0000_0008);
    rd(`ECT_OFF_HOLD + 12'h004);
    chk("hold1 guarded", 32'(v[15:0] < mid[15:0]), 32'h1);
    rd(`ECT_OFF_CAP + 12'h004);
    chk("cap1 kept", 32'(v[15:0] > mid[15:0]), 32'h1);
    $display("test latch done");

    wr(`ECT_OFF_SYS, 32'h0000_0007);
    pz(2, 257);
    pz(0, 257);
    rd(`ECT_OFF_ACC + 12'h008);
    chk("acc2 saturated", v, 32'h0000_00FF);
    rd(`ECT_OFF_ACC);
    chk("pair low byte", v, 32'h1);
    rd(`ECT_OFF_ACC + 12'h004);
    chk("pair high byte", v, 32'h1);
    $display("test accumulators done");

    wr(`ECT_OFF_MODFLG, 32'h0000_0001);
    wr(`ECT_OFF_MODCNT, 32'h0000_000A);
    wr(`ECT_OFF_MODCTL, 32'h0000_0001);
    wait_flag();
    wr(`ECT_OFF_MODFLG, 32'h0000_0001);
    repeat (60) @(posedge mclk);
    chk("one shot quiet", 32'(modZeroFlag), 32'h0);
    wr(`ECT_OFF_MODCNT, 32'h0000_000A);
    wr(`ECT_OFF_MODCTL, 32'h0000_0007);
    wait_flag();
    rd(`ECT_OFF_ACCH + 12'h008);
    chk("acch2 on zero", v, 32'h0000_00FF);
    wr(`ECT_OFF_MODFLG, 32'h0000_0001);
    wait_flag();
    wr(`ECT_OFF_MODCTL, 32'h0000_0000);
    $display("test modulus done");

    wr(`ECT_OFF_DELAY, 32'h0000_0003);
    pins.pulse(6, 1, 20);
    repeat (100) @(posedge mclk);
    rd(`ECT_OFF_STATUS);
    chk("glitch rejected", 32'(v[6]), 32'h0);
    pins.pulse(6, 1, 80);
    repeat (100) @(posedge mclk);
    rd(`ECT_OFF_STATUS);
    chk("long pulse kept", 32'(v[6]), 32'h1);
    $display("test delay done");
    finish_test();
  end
endmodule

// File: verif/ect_pin_model.sv
`timescale 1ns/1ps
module ect_pin_model (
  input wire logic mclk,     // module clock
  output logic [7:0] capPin  // capture pins
);
  // ==========================================================
  // edge source, pins rest low between pulses
  initial capPin = 8'h00;

  // n pulses, each w cycles high then w cycles low
  task automatic pulse(input int ch, input int n, input int w);
    repeat (n) begin
      @(posedge mclk);
      capPin[ch] <= 1'b1;
      repeat (w) @(posedge mclk);
      capPin[ch] <= 1'b0;
      repeat (w) @(posedge mclk);
    end
  endtask
endmodule
